// ---- tsa_pkg.sv ----
// Constants for the temperature sensor mode sequencer and alarm logic.
// Assumes a single 125 MHz system clock and a serial host on plain SPI pins.
`default_nettype none

package tsa_pkg;

  // System clock rate, in kHz so that cycle products stay within 32 bits
  localparam int unsigned CLK_KHZ = 125000;

  // Timing figures in milliseconds as documented
  localparam int unsigned CONV_TIME_MS = 240;
  localparam int unsigned ONESEC_CONV_MS = 60;
  localparam int unsigned ONESEC_IDLE_MS = 940;
  localparam int unsigned WAKE_TIME_MS = 1;

  // Derived cycle counts
  localparam int unsigned CONV_CYC = CONV_TIME_MS * CLK_KHZ;
  localparam int unsigned ONESEC_CONV_CYC = ONESEC_CONV_MS * CLK_KHZ;
  localparam int unsigned ONESEC_IDLE_CYC = ONESEC_IDLE_MS * CLK_KHZ;
  localparam int unsigned WAKE_CYC = WAKE_TIME_MS * CLK_KHZ;

  // Register addresses
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_SETUP = 3'h1;
  localparam logic [2:0] ADDR_RESULT = 3'h2;
  localparam logic [2:0] ADDR_IDENT = 3'h3;
  localparam logic [2:0] ADDR_CRIT = 3'h4;
  localparam logic [2:0] ADDR_HYST = 3'h5;
  localparam logic [2:0] ADDR_HIGH = 3'h6;
  localparam logic [2:0] ADDR_LOW = 3'h7;

  // Command byte layout
  localparam int CMD_READ_BIT = 6;
  localparam int CMD_ADDR_LSB = 3;

  // Reset values
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CRIT_RESET = 16'h4980;
  localparam logic [7:0] HYST_RESET = 8'h05;
  localparam logic [15:0] HIGH_RESET = 16'h2000;
  localparam logic [15:0] LOW_RESET = 16'h0500;
  // Arbitrary identity value
  localparam logic [7:0] IDENT_VALUE = 8'h5a;

  // Setup register fields
  localparam int SETUP_QUEUE_LSB = 0;
  localparam int SETUP_CRIT_POL = 2;
  localparam int SETUP_LIMIT_POL = 3;
  localparam int SETUP_CMP_MODE = 4;
  localparam int SETUP_MODE_LSB = 5;
  localparam int SETUP_WIDE = 7;

  // Status register fields
  localparam int STAT_LOW = 4;
  localparam int STAT_HIGH = 5;
  localparam int STAT_CRIT = 6;
  localparam int STAT_RDY_N = 7;

  // Hysteresis register holds whole degrees; a 16-bit code has 7 fraction bits
  localparam int HYST_SHIFT = 7;
  // Fraction bits dropped by the 13-bit format
  localparam logic [15:0] NARROW_MASK = 16'hfff8;

  typedef enum logic [1:0] {
    MODE_CONT = 2'b00,
    MODE_ONESHOT = 2'b01,
    MODE_ONESEC = 2'b10,
    MODE_SHUT = 2'b11
  } tsa_mode_t;

  typedef enum logic [1:0] {
    SEQ_SHUT = 2'b00,
    SEQ_WAKE = 2'b01,
    SEQ_CONV = 2'b10,
    SEQ_PAUSE = 2'b11
  } tsa_seq_t;

endpackage : tsa_pkg

`default_nettype wire

// ---- tsa_mode_alarm.sv ----
// Conversion sequencer, fault queue, alarm pins and SPI register access.
// Assumes sensorCode is a 16-bit code from the modulator on clk; SPI pins are asynchronous.
`default_nettype none

// How it works
// - Setup mode 01 runs one conversion immediately, then shuts down.
// - Each new one-shot conversion starts on a fresh mode write of 01.
// - Mode 10 converts 60 ms then idles 940 ms, once per second.
// - Interrupt mode clears both alarm pins on any register read.
// - Comparator one-shot: mode write clears limit alarm once inside hysteresis band.
// - Comparator one-shot: mode write clears critical alarm once below critical minus hysteresis.
// - Mode 11 shuts down; mode 00 returns to continuous operation.
// - Leaving shutdown with mode 00 waits about 1 ms, then converts; modes 01 and 10 start converting at once.
// - Last result stays readable during shutdown.
// - Setup bits 1:0 pick one to four consecutive faults before alarms.
// - A conversion inside all limits clears the fault counter.
// - Each result is compared with critical, high and low limits.
// - Default result is 13-bit two's complement, 0.0625 degree steps; limits are compared with the 13-bit code in that format.
// - In 13-bit format result bits 2:0 are critical, high, low flags.
// - Setup bit 7 selects full 16-bit results; default is 13-bit.
// - Continuous mode restarts a 240 ms conversion after each one.
// - Setup bit 4 selects interrupt mode (0) or comparator mode (1).
module tsa_mode_alarm #(
  parameter int unsigned CONV_CYCLES = tsa_pkg::CONV_CYC,
  parameter int unsigned ONESEC_CONV_CYCLES = tsa_pkg::ONESEC_CONV_CYC,
  parameter int unsigned ONESEC_IDLE_CYCLES = tsa_pkg::ONESEC_IDLE_CYC,
  parameter int unsigned WAKE_CYCLES = tsa_pkg::WAKE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] sensorCode,
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiDin,
  output logic spiDout,
  output logic spiDoutOe,
  output logic criticalAlarmOut,
  output logic criticalAlarmOutOe,
  output logic limitAlarmOut,
  output logic limitAlarmOutOe
);

  if (CONV_CYCLES < 1 || ONESEC_CONV_CYCLES < 1 || ONESEC_IDLE_CYCLES < 1 || WAKE_CYCLES < 1)
  begin : gBadTiming
    $error("tsa_mode_alarm: every timing count must be at least one cycle");
  end

  // Pin synchronisers
  logic sclkS1_reg, sclkS2_reg, sclkS3_reg;
  logic csNS1_reg, csNS2_reg;
  logic dinS1_reg, dinS2_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclkS1_reg <= 1'b0;
      sclkS2_reg <= 1'b0;
      sclkS3_reg <= 1'b0;
      csNS1_reg <= 1'b1;
      csNS2_reg <= 1'b1;
      dinS1_reg <= 1'b0;
      dinS2_reg <= 1'b0;
    end else begin
      sclkS1_reg <= spiClk;
      sclkS2_reg <= sclkS1_reg;
      sclkS3_reg <= sclkS2_reg;
      csNS1_reg <= spiCsN;
      csNS2_reg <= csNS1_reg;
      dinS1_reg <= spiDin;
      dinS2_reg <= dinS1_reg;
    end
  end

  logic sclkRise, sclkFall;
  assign sclkRise = sclkS2_reg & ~sclkS3_reg;
  assign sclkFall = ~sclkS2_reg & sclkS3_reg;

  // Serial framing state
  logic [4:0] bitCnt_reg;
  logic [15:0] rxShift_reg;
  logic [15:0] txShift_reg;
  logic isRead_reg;
  logic [2:0] addr_reg;

  logic newBit, cmdDone, wrDone, readPulse;
  logic [7:0] cmdByte;
  logic [15:0] wrWord;
  logic [2:0] cmdAddr;
  logic wideAddr;

  assign newBit = sclkRise & ~csNS2_reg & (bitCnt_reg != 5'h1f);
  assign cmdByte = {rxShift_reg[6:0], dinS2_reg};
  assign cmdAddr = cmdByte[tsa_pkg::CMD_ADDR_LSB +: 3];
  assign cmdDone = newBit & (bitCnt_reg == 5'h07);
  assign readPulse = cmdDone & cmdByte[tsa_pkg::CMD_READ_BIT];
  assign wideAddr = (addr_reg == tsa_pkg::ADDR_RESULT) | (addr_reg == tsa_pkg::ADDR_CRIT) |
                    (addr_reg == tsa_pkg::ADDR_HIGH) | (addr_reg == tsa_pkg::ADDR_LOW);
  assign wrDone = newBit & ~isRead_reg &
                  (bitCnt_reg == (wideAddr ? 5'h17 : 5'h0f));
  assign wrWord = {rxShift_reg[14:0], dinS2_reg};

  // Registers
  logic [7:0] setup_reg;
  logic [15:0] result_reg;
  logic [15:0] crit_reg, high_reg, low_reg;
  logic [7:0] hyst_reg;
  logic rdyN_reg;
  logic [2:0] statFlags_reg;

  logic modeWrite;
  tsa_pkg::tsa_mode_t curMode, newMode;
  assign modeWrite = wrDone & (addr_reg == tsa_pkg::ADDR_SETUP);
  assign curMode = tsa_pkg::tsa_mode_t'(setup_reg[tsa_pkg::SETUP_MODE_LSB +: 2]);
  assign newMode = tsa_pkg::tsa_mode_t'(wrWord[tsa_pkg::SETUP_MODE_LSB +: 2]);

  always_ff @(posedge clk) begin
    if (reset || csNS2_reg) begin
      bitCnt_reg <= 5'h00;
    end else if (newBit) begin
      bitCnt_reg <= bitCnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rxShift_reg <= 16'h0000;
      isRead_reg <= 1'b0;
      addr_reg <= 3'h0;
    end else if (newBit) begin
      rxShift_reg <= wrWord;
      if (cmdDone) begin
        isRead_reg <= cmdByte[tsa_pkg::CMD_READ_BIT];
        addr_reg <= cmdAddr;
      end
    end
  end

  // Read data, left aligned so the first bit out is the MSB
  logic [15:0] readValue;
  always_comb begin
    readValue = 16'h0000;
    unique case (cmdAddr)
      tsa_pkg::ADDR_STATUS: readValue = {rdyN_reg, statFlags_reg, 4'h0, 8'h00};
      tsa_pkg::ADDR_SETUP: readValue = {setup_reg, 8'h00};
      tsa_pkg::ADDR_RESULT: readValue = result_reg;
      tsa_pkg::ADDR_IDENT: readValue = {tsa_pkg::IDENT_VALUE, 8'h00};
      tsa_pkg::ADDR_CRIT: readValue = crit_reg;
      tsa_pkg::ADDR_HYST: readValue = {hyst_reg, 8'h00};
      tsa_pkg::ADDR_HIGH: readValue = high_reg;
      tsa_pkg::ADDR_LOW: readValue = low_reg;
    endcase
  end

  // Output bits change on falling edges so the host samples them on rising edges
  always_ff @(posedge clk) begin
    if (reset) begin
      txShift_reg <= 16'h0000;
      spiDout <= 1'b0;
    end else if (readPulse) begin
      txShift_reg <= readValue;
    end else if (sclkFall && !csNS2_reg && isRead_reg && bitCnt_reg >= 5'h08) begin
      spiDout <= txShift_reg[15];
      txShift_reg <= {txShift_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      spiDoutOe <= 1'b0;
    end else begin
      spiDoutOe <= ~csNS2_reg;
    end
  end

  // Writable registers; result, status and identity ignore writes
  always_ff @(posedge clk) begin
    if (reset) begin
      setup_reg <= tsa_pkg::SETUP_RESET;
      crit_reg <= tsa_pkg::CRIT_RESET;
      hyst_reg <= tsa_pkg::HYST_RESET;
      high_reg <= tsa_pkg::HIGH_RESET;
      low_reg <= tsa_pkg::LOW_RESET;
    end else if (wrDone) begin
      unique case (addr_reg)
        tsa_pkg::ADDR_SETUP: setup_reg <= wrWord[7:0];
        tsa_pkg::ADDR_CRIT: crit_reg <= wrWord;
        tsa_pkg::ADDR_HYST: hyst_reg <= wrWord[7:0];
        tsa_pkg::ADDR_HIGH: high_reg <= wrWord;
        tsa_pkg::ADDR_LOW: low_reg <= wrWord;
        default: ;
      endcase
    end
  end

  // Conversion sequencer
  tsa_pkg::tsa_seq_t seq_reg;
  logic [31:0] timer_reg;
  logic convDone;
  assign convDone = (seq_reg == tsa_pkg::SEQ_CONV) && (timer_reg == 32'h0);

  always_ff @(posedge clk) begin
    if (reset) begin
      seq_reg <= tsa_pkg::SEQ_CONV;
      timer_reg <= 32'(CONV_CYCLES - 1);
    end else if (modeWrite) begin
      unique case (newMode)
        tsa_pkg::MODE_SHUT: seq_reg <= tsa_pkg::SEQ_SHUT;
        // a one-shot write always starts a fresh conversion
        tsa_pkg::MODE_ONESHOT: begin
          seq_reg <= tsa_pkg::SEQ_CONV;
          timer_reg <= 32'(CONV_CYCLES - 1);
        end
        tsa_pkg::MODE_ONESEC: begin
          seq_reg <= tsa_pkg::SEQ_CONV;
          timer_reg <= 32'(ONESEC_CONV_CYCLES - 1);
        end
        tsa_pkg::MODE_CONT: begin
          // leave shutdown through the wake-up delay
          if (seq_reg == tsa_pkg::SEQ_SHUT) begin
            seq_reg <= tsa_pkg::SEQ_WAKE;
            timer_reg <= 32'(WAKE_CYCLES - 1);
          end else if (seq_reg == tsa_pkg::SEQ_PAUSE) begin
            seq_reg <= tsa_pkg::SEQ_CONV;
            timer_reg <= 32'(CONV_CYCLES - 1);
          end
        end
      endcase
    end else if (seq_reg != tsa_pkg::SEQ_SHUT && timer_reg != 32'h0) begin
      timer_reg <= timer_reg - 32'h1;
    end else begin
      unique case (seq_reg)
        tsa_pkg::SEQ_SHUT: ;
        tsa_pkg::SEQ_WAKE: begin
          seq_reg <= tsa_pkg::SEQ_CONV;
          timer_reg <= (curMode == tsa_pkg::MODE_ONESEC) ?
                       32'(ONESEC_CONV_CYCLES - 1) : 32'(CONV_CYCLES - 1);
        end
        tsa_pkg::SEQ_CONV: begin
          unique case (curMode)
            tsa_pkg::MODE_CONT: timer_reg <= 32'(CONV_CYCLES - 1);
            // idle for the rest of the second
            tsa_pkg::MODE_ONESEC: begin
              seq_reg <= tsa_pkg::SEQ_PAUSE;
              timer_reg <= 32'(ONESEC_IDLE_CYCLES - 1);
            end
            default: seq_reg <= tsa_pkg::SEQ_SHUT;
          endcase
        end
        tsa_pkg::SEQ_PAUSE: begin
          seq_reg <= tsa_pkg::SEQ_CONV;
          timer_reg <= 32'(ONESEC_CONV_CYCLES - 1);
        end
      endcase
    end
  end

  // Limit comparison, done on the code the result format will keep
  logic wideFmt;
  logic signed [15:0] sample, critS, highS, lowS, hystS;
  logic overCrit, overHigh, underLow, anyFault;
  logic critClear, limitClear;
  assign wideFmt = setup_reg[tsa_pkg::SETUP_WIDE];
  // 13-bit format drops the three lowest fraction bits
  assign sample = signed'(wideFmt ? sensorCode : (sensorCode & tsa_pkg::NARROW_MASK));
  assign critS = signed'(crit_reg);
  assign highS = signed'(high_reg);
  assign lowS = signed'(low_reg);
  // Whole degrees scaled to the 16-bit code, kept at the code's own width
  assign hystS = signed'(16'(hyst_reg) << tsa_pkg::HYST_SHIFT);
  assign overCrit = sample > critS;
  assign overHigh = sample > highS;
  assign underLow = sample < lowS;
  assign anyFault = overCrit | overHigh | underLow;
  assign critClear = sample < (critS - hystS);
  assign limitClear = (sample < (highS - hystS)) & (sample > (lowS + hystS));

  // Result register and ready flag
  always_ff @(posedge clk) begin
    if (reset) begin
      result_reg <= tsa_pkg::RESULT_RESET;
    end else if (convDone) begin
      // flag bits only in 13-bit format
      result_reg <= wideFmt ? sensorCode :
                    {sample[15:3], overCrit, overHigh, underLow};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdyN_reg <= 1'b1;
    end else if (convDone) begin
      rdyN_reg <= 1'b0;
    end else if ((readPulse && cmdAddr == tsa_pkg::ADDR_RESULT) ||
                 (modeWrite && curMode != tsa_pkg::MODE_CONT)) begin
      rdyN_reg <= 1'b1;
    end
  end

  // Status flags: a status read clears them unless a conversion completes that cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      statFlags_reg <= 3'h0;
    end else begin
      if (readPulse && cmdAddr == tsa_pkg::ADDR_STATUS) begin
        statFlags_reg <= 3'h0;
      end
      if (convDone) begin
        statFlags_reg[0] <= underLow | (statFlags_reg[0] & ~(sample > (lowS + hystS)));
        statFlags_reg[1] <= overHigh | (statFlags_reg[1] & ~(sample < (highS - hystS)));
        statFlags_reg[2] <= overCrit | (statFlags_reg[2] & ~critClear);
      end
    end
  end

  // Fault queue
  logic [1:0] faultCnt_reg;
  logic qualified;
  // alarm only after the programmed number of consecutive faults
  assign qualified = convDone & anyFault &
                     (faultCnt_reg >= setup_reg[tsa_pkg::SETUP_QUEUE_LSB +: 2]);

  always_ff @(posedge clk) begin
    if (reset) begin
      faultCnt_reg <= 2'h0;
    end else if (convDone) begin
      if (!anyFault) begin
        faultCnt_reg <= 2'h0;
      // same queue for every conversion mode
      end else if (faultCnt_reg != 2'h3) begin
        faultCnt_reg <= faultCnt_reg + 2'h1;
      end
    end
  end

  // Alarm state; a setting event wins over any clear in the same cycle
  logic critAlarm_reg, limitAlarm_reg;
  logic critInside_reg, limitInside_reg;
  logic cmpMode, oneShotUse;
  assign cmpMode = setup_reg[tsa_pkg::SETUP_CMP_MODE];
  assign oneShotUse = curMode == tsa_pkg::MODE_ONESHOT;

  always_ff @(posedge clk) begin
    if (reset) begin
      critInside_reg <= 1'b1;
      limitInside_reg <= 1'b1;
    end else if (convDone) begin
      critInside_reg <= critClear;
      limitInside_reg <= limitClear;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      critAlarm_reg <= 1'b0;
    end else if (qualified && overCrit) begin
      critAlarm_reg <= 1'b1;
    // interrupt mode clears on any read
    end else if (!cmpMode && readPulse) begin
      critAlarm_reg <= 1'b0;
    // one-shot comparator clears on a mode write
    end else if (cmpMode && oneShotUse && modeWrite && critInside_reg) begin
      critAlarm_reg <= 1'b0;
    end else if (cmpMode && !oneShotUse && convDone && critClear) begin
      critAlarm_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      limitAlarm_reg <= 1'b0;
    end else if (qualified && (overHigh || underLow)) begin
      limitAlarm_reg <= 1'b1;
    // interrupt mode clears on any read
    end else if (!cmpMode && readPulse) begin
      limitAlarm_reg <= 1'b0;
    // one-shot comparator clears on a mode write
    end else if (cmpMode && oneShotUse && modeWrite && limitInside_reg) begin
      limitAlarm_reg <= 1'b0;
    end else if (cmpMode && !oneShotUse && convDone && limitClear) begin
      limitAlarm_reg <= 1'b0;
    end
  end

  // Open-drain pins only pull low; active-high polarity pulls while idle
  always_ff @(posedge clk) begin
    if (reset) begin
      criticalAlarmOut <= 1'b0;
      limitAlarmOut <= 1'b0;
      criticalAlarmOutOe <= 1'b0;
      limitAlarmOutOe <= 1'b0;
    end else begin
      criticalAlarmOut <= 1'b0;
      limitAlarmOut <= 1'b0;
      criticalAlarmOutOe <= critAlarm_reg ^ setup_reg[tsa_pkg::SETUP_CRIT_POL];
      limitAlarmOutOe <= limitAlarm_reg ^ setup_reg[tsa_pkg::SETUP_LIMIT_POL];
    end
  end

endmodule : tsa_mode_alarm

`default_nettype wire

// ---- tsa_mode_alarm_chk.sv ----
// Port-level assertions for the serial output and alarm pins.
// Bound to tsa_mode_alarm; every signal is sampled on clk, though the SPI pins are asynchronous.
`default_nettype none
module tsa_mode_alarm_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] sensorCode,
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiDin,
  input wire logic spiDout,
  input wire logic spiDoutOe,
  input wire logic criticalAlarmOut,
  input wire logic criticalAlarmOutOe,
  input wire logic limitAlarmOut,
  input wire logic limitAlarmOutOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Host stays away from the link, so only a conversion can move a pin
  sequence csIdle;
    spiCsN [*8];
  endsequence
  sequence limitRise;
    $rose(limitAlarmOutOe) ##1 csIdle;
  endsequence
  sequence critRise;
    $rose(criticalAlarmOutOe) ##1 csIdle;
  endsequence

  a_dout_off_idle: assert property (
    spiCsN && $past(spiCsN) && $past(spiCsN, 2) && $past(spiCsN, 3) |-> !spiDoutOe)
    else $error("data output driven while deselected");
  a_dout_on_sel: assert property (
    !spiCsN && !$past(spiCsN) && !$past(spiCsN, 2) && !$past(spiCsN, 3) |-> spiDoutOe)
    else $error("data output not driven while selected");
  a_dout_fall_edge: assert property (
    $changed(spiDout) |-> !$past(spiClk) && !$past(spiClk, 2))
    else $error("data output moved outside a low clock phase");
  a_dout_bit_hold: assert property (
    $changed(spiDout) && !spiCsN |=> $stable(spiDout) [*3])
    else $error("data output bit held too briefly");
  a_crit_drive_zero: assert property (
    !criticalAlarmOut)
    else $error("critical pin drives high");
  a_limit_drive_zero: assert property (
    !limitAlarmOut)
    else $error("limit pin drives high");
  a_limit_hold_idle: assert property (
    limitRise |-> limitAlarmOutOe)
    else $error("limit alarm dropped with no host access");
  a_crit_hold_idle: assert property (
    critRise |-> criticalAlarmOutOe)
    else $error("critical alarm dropped with no host access");
  a_pins_after_reset: assert property (
    $fell(reset) |-> !limitAlarmOutOe && !criticalAlarmOutOe && !spiDoutOe)
    else $error("pins active straight after reset");
endmodule : tsa_mode_alarm_chk
`default_nettype wire

// ---- tsa_spi_host.sv ----
// Serial host model: frames of command byte then data, MSB first.
// Assumes clk is the device clock; a link half period is five clk cycles.
`default_nettype none
module tsa_spi_host (
  input wire logic clk,
  input wire logic doutWire,
  output logic spiClk,
  output logic spiCsN,
  output logic spiDin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiDin = 1'b0;
  end
  task automatic half;
    repeat (5) @(negedge clk);
  endtask : half
  // whole frame; result holds the nBits read bits right aligned, clock idles low
  task automatic frame(input logic [7:0] cmd, input logic [15:0] wr, input int nBits,
                       output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wr};
    rd = 16'h0000;
    @(negedge clk);
    spiCsN = 1'b0;
    for (int i = 0; i < 8 + nBits; i++) begin
      spiDin = sh[23 - i];
      half();
      if (i >= 8) rd = {rd[14:0], doutWire};
      spiClk = 1'b1;
      half();
      spiClk = 1'b0;
    end
    half();
    spiCsN = 1'b1;
    // Released line shows no stale value
    spiDin = ~spiDin;
    half();
  endtask : frame
endmodule : tsa_spi_host
`default_nettype wire

// ---- tsa_mode_alarm_test.sv ----
// Self-checking bench for tsa_mode_alarm through its serial register link.
// Assumes shortened conversion counts; the host model drives the link pins.
`default_nettype none
module tsa_mode_alarm_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 200;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] sensorCode = 16'h0000;
  logic spiClk, spiCsN, spiDin, spiDout, spiDoutOe, doutWire;
  logic criticalAlarmOut, criticalAlarmOutOe, limitAlarmOut, limitAlarmOutOe;
  logic lastDout = 1'b0;
  logic [15:0] rv;
  logic [7:0] r8;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  tsa_mode_alarm #(.CONV_CYCLES(CONV), .ONESEC_CONV_CYCLES(50), .ONESEC_IDLE_CYCLES(100),
    .WAKE_CYCLES(20)) uut (.clk(clk), .reset(reset), .sensorCode(sensorCode),
    .spiClk(spiClk), .spiCsN(spiCsN), .spiDin(spiDin), .spiDout(spiDout),
    .spiDoutOe(spiDoutOe), .criticalAlarmOut(criticalAlarmOut),
    .criticalAlarmOutOe(criticalAlarmOutOe), .limitAlarmOut(limitAlarmOut),
    .limitAlarmOutOe(limitAlarmOutOe));
  tsa_spi_host host (.clk(clk), .doutWire(doutWire), .spiClk(spiClk), .spiCsN(spiCsN),
    .spiDin(spiDin));

  // Undriven data line shows the inverse of its last level
  always @(posedge clk) if (spiDoutOe === 1'b1) lastDout <= spiDout;
  assign doutWire = (spiDoutOe === 1'b1) ? spiDout : ~lastDout;

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      final_report();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    logic [15:0] unused;
    host.frame({2'b00, a, 3'b000}, {d, 8'h00}, 8, unused);
  endtask : wr8
  task automatic rd8(input logic [2:0] a, output logic [7:0] d);
    logic [15:0] t;
    host.frame({2'b01, a, 3'b000}, 16'h0000, 8, t);
    d = t[7:0];
  endtask : rd8
  task automatic rd16(input logic [2:0] a, output logic [15:0] d);
    host.frame({2'b01, a, 3'b000}, 16'h0000, 16, d);
  endtask : rd16
  task automatic pins(input logic crit, input logic lim, input string what);
    check({15'h0, criticalAlarmOutOe}, {15'h0, crit}, what);
    check({15'h0, limitAlarmOutOe}, {15'h0, lim}, what);
  endtask : pins

  initial begin
    cyc(16);
    reset = 1'b0;
    cyc(4);
    rd8(tsa_pkg::ADDR_SETUP, r8);
    check({8'h00, r8}, {8'h00, tsa_pkg::SETUP_RESET}, "setup reset");
    sensorCode = 16'h0c87;
    cyc(2 * CONV + 50);
    rd16(tsa_pkg::ADDR_RESULT, rv);
    check(rv, 16'h0c80, "narrow result");
    check({7'h00, rv[15:7]}, 16'd25, "whole degrees");
    check(rv & 16'hff80, 16'h0c80, "nine-bit view");
    $display("test 1 done");
    wr8(tsa_pkg::ADDR_SETUP, 8'h80);
    cyc(2 * CONV + 50);
    rd16(tsa_pkg::ADDR_RESULT, rv);
    check(rv, 16'h0c87, "wide result");
    pins(1'b0, 1'b0, "no alarm in band");
    $display("test 2 done");
    wr8(tsa_pkg::ADDR_SETUP, 8'he0);
    cyc(CONV + 50);
    sensorCode = 16'h0d00;
    cyc(2 * CONV + 50);
    rd16(tsa_pkg::ADDR_RESULT, rv);
    check(rv, 16'h0c87, "kept in shutdown");
    $display("test 3 done");
    wr8(tsa_pkg::ADDR_SETUP, 8'ha0);
    cyc(CONV + 50);
    rd16(tsa_pkg::ADDR_RESULT, rv);
    check(rv, 16'h0d00, "one-shot result");
    sensorCode = 16'h0d80;
    cyc(2 * CONV + 50);
    rd16(tsa_pkg::ADDR_RESULT, rv);
    check(rv, 16'h0d00, "idle after one-shot");
    wr8(tsa_pkg::ADDR_SETUP, 8'ha0);
    cyc(CONV + 50);
    rd16(tsa_pkg::ADDR_RESULT, rv);
    check(rv, 16'h0d80, "second one-shot");
    $display("test 4 done");
    sensorCode = 16'h2100;
    wr8(tsa_pkg::ADDR_SETUP, 8'hc3);
    cyc(400);
    pins(1'b0, 1'b0, "three faults only");
    cyc(150);
    pins(1'b0, 1'b1, "fourth fault");
    sensorCode = 16'h0c80;
    cyc(200);
    pins(1'b0, 1'b1, "held until read");
    rd8(tsa_pkg::ADDR_SETUP, r8);
    check({8'h00, r8}, 16'h00c3, "setup readback");
    pins(1'b0, 1'b0, "cleared by read");
    sensorCode = 16'h2100;
    cyc(100);
    pins(1'b0, 1'b0, "queue restarted");
    $display("test 5 done");
    sensorCode = 16'h4a00;
    wr8(tsa_pkg::ADDR_SETUP, 8'hb0);
    cyc(CONV + 50);
    pins(1'b1, 1'b1, "over critical");
    rd8(tsa_pkg::ADDR_SETUP, r8);
    pins(1'b1, 1'b1, "read keeps comparator");
    sensorCode = 16'h0c80;
    wr8(tsa_pkg::ADDR_SETUP, 8'hb0);
    cyc(CONV + 50);
    pins(1'b1, 1'b1, "cool result awaits write");
    wr8(tsa_pkg::ADDR_SETUP, 8'hb0);
    pins(1'b0, 1'b0, "mode write clears");
    $display("test 6 done");
    wr8(tsa_pkg::ADDR_SETUP, 8'he0);
    sensorCode = 16'h1000;
    cyc(CONV + 50);
    rd16(tsa_pkg::ADDR_RESULT, rv);
    check(rv, 16'h0c80, "shut before wake");
    wr8(tsa_pkg::ADDR_SETUP, 8'h80);
    cyc(CONV + 100);
    rd16(tsa_pkg::ADDR_RESULT, rv);
    check(rv, 16'h1000, "wake converts");
    wr8(tsa_pkg::ADDR_SETUP, 8'h8c);
    pins(1'b1, 1'b1, "polarity inverts idle pins");
    $display("test 7 done");
    final_report();
  end
endmodule : tsa_mode_alarm_test

bind tsa_mode_alarm tsa_mode_alarm_chk chk (.clk(clk), .reset(reset),
  .sensorCode(sensorCode), .spiClk(spiClk), .spiCsN(spiCsN), .spiDin(spiDin),
  .spiDout(spiDout), .spiDoutOe(spiDoutOe), .criticalAlarmOut(criticalAlarmOut),
  .criticalAlarmOutOe(criticalAlarmOutOe), .limitAlarmOut(limitAlarmOut),
  .limitAlarmOutOe(limitAlarmOutOe));
`default_nettype wire
